// ### core/ncd_defs.vh
// register map and timing constants for the nvm clock divider
// assumes a 32-bit apb slave, pclk at 200 MHz
// Functional notes
// - first write after reset sets loaded flag bit 7, any data
// - reset clears loaded flag and whole register to zero
// - loaded flag is read-only, changes only by reset or first write
// - bits 6..0 always readable, written only by the first write and only if its lane 0 strobe is set, later writes ignored
// - erase/program refused while flag is 0, allowed when 1
// - prescale bit 6 selects bus clock or bus clock divided by 8
// - divider input divided by bits 5..0 plus one
// - each timing pulse is one timing clock period; sequencer counts pulses
`ifndef NCD_DEFS_VH
`define NCD_DEFS_VH
`define NCD_SETTING_ADDR 12'h000
`define NCD_STATUS_ADDR 12'h004
`define NCD_SETTING_RESET 8'h00
`define NCD_LOADED_BIT 7
`define NCD_PRESCALE_BIT 6
`define NCD_DIVISOR_MSB 5
`define NCD_PRESCALE_COUNT 3'h7
`define NCD_SETTING_LANE 0
`define NCD_STATUS_LOADED_BIT 0
`define NCD_FIELD_RESET 7'h00
`define NCD_LOADED_RESET 1'b0
`define NCD_OUT_RESET 1'b0
`define NCD_RDATA_IDLE 32'h0000_0000
`endif

// ### core/ncd_pulse_gen.v
// counter chain making the one-cycle timing clock enable
// assumes settings are stable once run is high
`timescale 1ns/1ps
`include "ncd_defs.vh"
module ncd_pulse_gen (
	input wire pclk,
	input wire presetn,
	input wire run,
	input wire prescale_by_eight,
	input wire [5:0] divisor,
	output reg tick_q
);
	reg [2:0] pre_q;
	reg [5:0] div_q;
	wire pre_tick;
	// prescale stage: every cycle or every 8th
	assign pre_tick = prescale_by_eight ? (pre_q == `NCD_PRESCALE_COUNT) : 1'b1;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 3'h0;
			div_q <= 6'h00;
			tick_q <= 1'b0;
		end else if (!run) begin
			pre_q <= 3'h0;
			div_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			pre_q <= pre_q + 3'h1;
			tick_q <= 1'b0;
			if (pre_tick) begin
				if (div_q == divisor) begin
					div_q <= 6'h00;
					tick_q <= 1'b1;
				end else begin
					div_q <= div_q + 6'h01;
				end
			end
		end
	end
endmodule

// ### core/ncd_top.v
// nvm clock divider: write-once setting register on apb, timing enable
// assumes a standard apb master and a sequencer on pclk counting ticks
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ncd_defs.vh"
module ncd_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg divisor_loaded_flag,
	output reg nvm_timing_clock,
	output reg erase_program_enable,
	input wire op_request,
	output reg op_refused_q
);
	// write-once setting and its loaded flag
	reg [6:0] setting_q;
	reg [6:0] setting_d;
	reg loaded_q;
	reg loaded_d;

	// next values of the registered outputs
	reg [31:0] prdata_d;
	reg pready_d;
	reg pslverr_d;
	reg flag_d;
	reg enable_d;
	reg timing_d;
	reg refused_d;

	// bus decode
	wire setup;
	wire access_phase;
	wire hit_setting;
	wire hit_status;
	wire hit_none;
	wire rd_setup;
	wire lane_zero;
	wire first_write;
	wire [6:0] field_wdata;

	// read words and timing enable
	wire [31:0] setting_word;
	wire [31:0] status_word;
	wire tick;
	genvar gi;

	assign setup = psel && !penable;
	assign access_phase = psel && penable && pready;
	assign hit_setting = (paddr == `NCD_SETTING_ADDR);
	assign hit_status = (paddr == `NCD_STATUS_ADDR);
	assign hit_none = !hit_setting && !hit_status;
	assign rd_setup = setup && !pwrite;
	// lane 0 holds the whole setting field
	assign lane_zero = pstrb[`NCD_SETTING_LANE];
	assign field_wdata = pwdata[`NCD_PRESCALE_BIT:0];
	// later writes to the setting are dropped here
	assign first_write = access_phase && pwrite && hit_setting && !loaded_q;

	// read words, one loop pass per bit
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_rbit
			if (gi <= `NCD_PRESCALE_BIT) begin : g_field
				assign setting_word[gi] = setting_q[gi];
			end else if (gi == `NCD_LOADED_BIT) begin : g_flag
				assign setting_word[gi] = loaded_q;
			end else begin : g_pad
				assign setting_word[gi] = 1'b0;
			end
			if (gi == `NCD_STATUS_LOADED_BIT) begin : g_stat
				assign status_word[gi] = loaded_q;
			end else begin : g_spad
				assign status_word[gi] = 1'b0;
			end
		end
	endgenerate

	// timing enable counts only once the setting is loaded
	ncd_pulse_gen u_ncd_pulse_gen (
		.pclk(pclk),
		.presetn(presetn),
		.run(loaded_q),
		.prescale_by_eight(setting_q[`NCD_PRESCALE_BIT]),
		.divisor(setting_q[`NCD_DIVISOR_MSB:0]),
		.tick_q(tick)
	);

	// setting: lane 0 of the first write carries the field
	always @* begin
		setting_d = setting_q;
		if (first_write && lane_zero) begin
			setting_d = field_wdata;
		end
	end

	// flag: set by the first write whatever its data
	always @* begin
		loaded_d = loaded_q;
		if (first_write) begin
			loaded_d = 1'b1;
		end
	end

	// no wait state: pready comes in the first access cycle
	always @* begin
		pready_d = setup;
	end

	// unmapped addresses answer with an error
	always @* begin
		pslverr_d = setup && hit_none;
	end

	// read data stands only in the access cycle of a read
	always @* begin
		prdata_d = `NCD_RDATA_IDLE;
		if (rd_setup && hit_setting) begin
			prdata_d = setting_word;
		end else if (rd_setup && hit_status) begin
			prdata_d = status_word;
		end
	end

	always @* begin
		flag_d = loaded_q;
	end

	// erase and program gated by the loaded flag
	always @* begin
		enable_d = loaded_q;
	end

	// refusal shown while nothing is loaded
	always @* begin
		refused_d = op_request && !loaded_q;
	end

	always @* begin
		timing_d = tick;
	end

	// setting field: cleared only by reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setting_q <= `NCD_FIELD_RESET;
		end else begin
			setting_q <= setting_d;
		end
	end

	// loaded flag: cleared only by reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_q <= `NCD_LOADED_RESET;
		end else begin
			loaded_q <= loaded_d;
		end
	end

	// bus outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `NCD_RDATA_IDLE;
		end else begin
			prdata <= prdata_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= `NCD_OUT_RESET;
		end else begin
			pready <= pready_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= `NCD_OUT_RESET;
		end else begin
			pslverr <= pslverr_d;
		end
	end

	// flag and erase/program enable outputs follow the flag one cycle behind
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divisor_loaded_flag <= `NCD_OUT_RESET;
		end else begin
			divisor_loaded_flag <= flag_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_program_enable <= `NCD_OUT_RESET;
		end else begin
			erase_program_enable <= enable_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvm_timing_clock <= `NCD_OUT_RESET;
		end else begin
			nvm_timing_clock <= timing_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_refused_q <= `NCD_OUT_RESET;
		end else begin
			op_refused_q <= refused_d;
		end
	end
endmodule

// ### testbench/ncd_top_properties.sv
// checker of ncd_top; assumes binding onto its ports
`timescale 1ns/1ps
module ncd_chk(input pclk,presetn,psel,penable,pwrite,pready,op_request,op_refused_q,
	input erase_program_enable,divisor_loaded_flag,nvm_timing_clock,input [11:0] paddr);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ld=divisor_loaded_flag;
	wire wr=psel&&penable&&pwrite&&paddr==12'h000;
	property p_rdy; psel&&!penable |=> pready; endproperty
	a_rdy: assert property(p_rdy) else $error("rdy");
	property p_ld; wr&&pready&&!ld |-> ##[1:2] ld; endproperty
	a_ld: assert property(p_ld) else $error("ld");
	property p_set; $rose(ld) |-> $past(wr)||$past(wr,2); endproperty
	a_set: assert property(p_set) else $error("set");
	property p_keep; ld |=> ld; endproperty
	a_keep: assert property(p_keep) else $error("keep");
	property p_en; erase_program_enable==ld; endproperty
	a_en: assert property(p_en) else $error("en");
	property p_ref; op_request&&!ld&&!$past(wr) |=> op_refused_q; endproperty
	a_ref: assert property(p_ref) else $error("ref");
	property p_ok; $past(ld) |-> !op_refused_q; endproperty
	a_ok: assert property(p_ok) else $error("ok");
	property p_tk; nvm_timing_clock |-> ld; endproperty
	a_tk: assert property(p_tk) else $error("tk");
	c_wr: cover property(wr);
	c_tk: cover property(nvm_timing_clock);
	c_rf: cover property(op_refused_q);
endmodule
bind ncd_top ncd_chk u_chk(.*);

// ### testbench/ncd_top_tb.sv
// bench of ncd_top; assumes 5 ns pclk
`timescale 1ns/1ps
module ncd_top_tb;
logic pclk=0,presetn=0,psel=0,penable=0,pwrite=0,op_request=0;
logic [11:0] paddr='0;
logic [31:0] pwdata='0;
wire [31:0] prdata;
logic [3:0] pstrb=4'hf;
wire pready,pslverr,nvm_timing_clock,op_refused_q;
int err_total=0,n_tests=0,n;
ncd_top u_ncd_top(.*,.divisor_loaded_flag(),.erase_program_enable());
always #2.5 pclk=~pclk;
task end_sim;
	if (err_total==0&&n_tests>0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
task chk(input logic [31:0] s,e);
	n_tests++;
	err_total+=s!==e;
	if (s!==e) $display("CHECK FAILED %0t bad value",$time);
endtask
task wt(input bit p);
	n=0;
	do @(posedge pclk); while (++n<99&&(p?pready:nvm_timing_clock)!==1);
	chk(n<99,1'b1);
	if (n>98) end_sim;
endtask
task xf(input bit w,input logic [11:0] a,input logic [7:0] d,e);
	{psel,penable,pwrite,paddr,pwdata}<={2'b10,w,a,24'h00_0000,d};
	@(posedge pclk) penable<=1'b1;
	wt(1'b1);
	chk(prdata,{24'h00_0000,e});
	chk(pslverr,a>12'h004);
	{psel,penable}<=2'b00;
	@(posedge pclk);
endtask
task rst;
	presetn<=1'b0;
	repeat (2) @(posedge pclk);
	presetn<=1'b1;
endtask
initial begin
	repeat (5) @(posedge pclk);
	{presetn,op_request}<=2'b11;
	xf(0,12'h000,8'h00,8'h00);
	chk(op_refused_q,1'b1);
	xf(1,12'h000,8'h41,8'h00);
	xf(1,12'h000,8'h3f,8'h00);
	xf(0,12'h000,8'h00,8'hc1);
	xf(1,12'h008,8'h00,8'h00);
	wt(1'b0);
	wt(1'b0);
	chk(n,8'h10);
	rst;
	xf(0,12'h000,8'h00,8'h00);
	chk(op_refused_q,1'b1);
	pstrb<=4'h0;
	xf(1,12'h000,8'h03,8'h00);
	pstrb<=4'hf;
	xf(0,12'h000,8'h00,8'h80);
	chk(op_refused_q,1'b0);
	rst;
	xf(1,12'h000,8'h03,8'h00);
	xf(0,12'h004,8'h00,8'h01);
	wt(1'b0);
	wt(1'b0);
	chk(n,8'h04);
	end_sim;
end
endmodule
